// file: include/dsal_pkg.sv
package dsal_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000; // System clock rate
	localparam int unsigned TICK_PERIOD_MS = 1000; // Timer step, in ms
	// Cycles in one timer step; default of the top-level parameter
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
	localparam int unsigned MENU_TIMEOUT_S = 20; // Idle menu falls back
	localparam logic [4:0] MENU_TIMEOUT_TICKS = 5'h14; // 20 steps

	// ---------------------------------------------------------------
	// Limits and reset values
	// ---------------------------------------------------------------
	localparam int VAL_W = 18; // Signed display value width
	localparam logic [11:0] TIME_MAX_S = 12'he10; // 3600 seconds
	localparam logic [15:0] CODE_RESET = 16'h0000; // Factory access code
	localparam logic [15:0] CODE_OPEN = 16'h0000; // Code meaning no guard
	localparam logic ACSP_RESET = 1'b0; // Factory: direct menu off
	localparam logic signed [17:0] SP_RESET = 18'sh00000; // Setpoints
	localparam int SP_DIGITS = 5; // Editable setpoint digits
	localparam int CODE_DIGITS = 4; // Access code digits

	// Button positions in the button vector
	localparam int BTN_DOWN = 0;
	localparam int BTN_UP = 1;
	localparam int BTN_NEXT = 2; // P button: next digit or alarm accept
	localparam int BTN_EXIT = 3; // E button

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef logic signed [17:0] dsal_value_t;

	// Weight of each editable setpoint digit, least significant first
	localparam dsal_value_t DIGIT_WEIGHT [SP_DIGITS] = '{
		18'sh00001, 18'sh0000a, 18'sh00064, 18'sh003e8, 18'sh02710
	};

	// Per-channel alarm settings, all kept apart from the on/off bit
	typedef struct packed {
		logic enable; // Channel on
		logic high_low_select; // 1 high alarm, 0 low alarm
		logic normally_closed; // Output closed when not in alarm
		logic display_flash_option; // Alternate display with reference
		logic [15:0] deadband_value; // Hysteresis in display units
		logic [11:0] activation_delay; // Seconds
		logic [11:0] silence_time; // Seconds
	} dsal_chan_cfg_t;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_DELAY = 2'b01,
		CH_ACTIVE = 2'b10,
		CH_SILENCE = 2'b11
	} dsal_chan_state_t;

	typedef enum logic [2:0] {
		MN_DISPLAY = 3'b000,
		MN_CODE_PROMPT = 3'b001,
		MN_CODE_EDIT = 3'b010,
		MN_SP_PROMPT = 3'b011,
		MN_SP_EDIT = 3'b100
	} dsal_menu_t;

	typedef enum logic [1:0] {
		DISP_VALUE = 2'b00,
		DISP_REF_ONE = 2'b01,
		DISP_REF_TWO = 2'b10
	} dsal_disp_t;

	// Menu status shown to the display driver
	typedef struct packed {
		dsal_menu_t mode; // Current menu page
		logic chan; // Setpoint selected: 0 first, 1 second
		logic [2:0] digit; // Flashing digit index
		dsal_value_t edit_value; // Setpoint being edited
		logic [15:0] edit_code; // Code being entered, BCD
	} dsal_menu_stat_t;

endpackage

// file: design/dsal_alarm_logic.sv
`timescale 1ns/1ps
// Contract
// - Alarm starts when value reaches setpoint
// - Channel on/off keeps other settings
// - Setpoint limited to 3.8-20.2 mA range
// - Each channel high or low alarm
// - Output sense selectable, inverted in alarm
// - High alarm clears below setpoint minus hysteresis
// - Activation delay 0-3600 s, zero none
// - Output trips after uninterrupted full delay
// - Annunciator flashes while delayed, steady after
// - Nonzero silence makes P an accept
// - Accept returns output to non-alarm for silence
// - Reactivate after silence if condition remains
// - Annunciator flashes during silence period
// - Display alternates value and channel reference
// - No display flash in silence or delay
// - Both active: references shown in sequence
// - Direct setpoint menu blocked while off
// - Separate four-digit direct menu code
// - Code 0000 grants access without entry
// - Reset: direct menu off, code 0000
// - Digit editing with up/down/next, E stores
module dsal_alarm_logic
	import dsal_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire dsal_value_t display_value,
	input wire dsal_value_t sp_low_limit,
	input wire dsal_value_t sp_high_limit,
	input wire dsal_chan_cfg_t chan_cfg [2],
	input wire logic [3:0] buttons,
	input wire logic sp_load,
	input wire logic sp_load_chan,
	input wire dsal_value_t sp_load_value,
	input wire logic menu_cfg_load,
	input wire logic direct_trip_point_menu_in,
	input wire logic [15:0] direct_menu_code_in,
	output logic [1:0] alarm_switch_closed,
	output logic [1:0] annunciator_on,
	output dsal_disp_t display_select,
	output dsal_value_t first_trip_point,
	output dsal_value_t second_trip_point,
	output logic direct_trip_point_menu,
	output logic [15:0] direct_menu_code,
	output dsal_menu_stat_t menu_stat
);

	// ---------------------------------------------------------------
	// Timer base
	// ---------------------------------------------------------------
	logic [25:0] div_q; // Cycle counter within one step
	logic sec_tick; // One-cycle pulse every second
	logic half_tick; // One-cycle pulse every half second
	logic blink_q; // Annunciator blink phase

	assign sec_tick = (div_q == 26'(TICK_LEN - 1));
	assign half_tick = sec_tick || (div_q == 26'(TICK_LEN / 2 - 1));

	// Divider: single clock, slower rates are enables only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= 26'h0000000;
		end else if (sec_tick) begin
			div_q <= 26'h0000000;
		end else begin
			div_q <= div_q + 26'h0000001;
		end
	end

	// Blink phase toggles twice a second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blink_q <= 1'b0;
		end else if (half_tick) begin
			blink_q <= ~blink_q;
		end
	end

	// ---------------------------------------------------------------
	// Push buttons
	// ---------------------------------------------------------------
	logic [3:0] btn_meta_q; // First stage, read only by the second
	logic [3:0] btn_sync_q; // Synchronised level
	logic [3:0] btn_prev_q; // Previous level, for edge detection
	logic [3:0] btn_press; // One-cycle press events

	// Buttons are asynchronous pins, so two flops before any use
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			btn_meta_q <= 4'h0;
			btn_sync_q <= 4'h0;
			btn_prev_q <= 4'h0;
		end else begin
			btn_meta_q <= buttons;
			btn_sync_q <= btn_meta_q;
			btn_prev_q <= btn_sync_q;
		end
	end

	assign btn_press = btn_sync_q & ~btn_prev_q;

	logic combo_press; // P and up together opens the direct menu
	logic accept_press; // P pressed without up held, in any menu page
	assign combo_press = (btn_press[BTN_NEXT] && btn_sync_q[BTN_UP]) ||
		(btn_press[BTN_UP] && btn_sync_q[BTN_NEXT]);
	assign accept_press = btn_press[BTN_NEXT] && !btn_sync_q[BTN_UP];

	// ---------------------------------------------------------------
	// Direct setpoint menu
	// ---------------------------------------------------------------
	dsal_menu_t menu_q; // Current page
	logic chan_sel_q; // Selected setpoint
	logic [2:0] digit_q; // Flashing digit
	dsal_value_t edit_val_q; // Setpoint work copy
	logic [15:0] edit_code_q; // Code work copy
	logic [4:0] idle_cnt_q; // Seconds without a button
	dsal_value_t sp_q [2]; // Stored setpoints
	logic acsp_q; // Direct menu enabled
	logic [15:0] code_q; // Direct menu access code
	logic sp_store; // Store work copy into selected setpoint
	logic any_press;
	logic menu_timeout;

	assign any_press = |btn_press;
	assign menu_timeout = (idle_cnt_q >= MENU_TIMEOUT_TICKS);
	assign sp_store = (menu_q == MN_SP_EDIT) && btn_press[BTN_EXIT];

	// Step one BCD digit up or down with wrap-round
	function automatic logic [3:0] bcd_step(input logic [3:0] d,
		input logic up);
		logic [3:0] r;
		r = d;
		if (up) begin
			r = (d >= 4'h9) ? 4'h0 : d + 4'h1;
		end else begin
			r = (d == 4'h0) ? 4'h9 : d - 4'h1;
		end
		return r;
	endfunction

	// Keep a setpoint inside the span that maps to 3.8-20.2 mA
	function automatic dsal_value_t sp_clamp(input logic signed [19:0] v);
		dsal_value_t r;
		r = v[17:0];
		if (v < 20'(sp_low_limit)) begin
			r = sp_low_limit;
		end else if (v > 20'(sp_high_limit)) begin
			r = sp_high_limit;
		end
		return r;
	endfunction

	// Idle timer: twenty quiet seconds abandon the menu
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			idle_cnt_q <= 5'h00;
		end else if (any_press || menu_q == MN_DISPLAY) begin
			idle_cnt_q <= 5'h00;
		end else if (sec_tick && !menu_timeout) begin
			idle_cnt_q <= idle_cnt_q + 5'h01;
		end
	end

	// Menu page sequencing and digit editing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			menu_q <= MN_DISPLAY;
			chan_sel_q <= 1'b0;
			digit_q <= 3'h0;
			edit_val_q <= SP_RESET;
			edit_code_q <= CODE_RESET;
		end else if (menu_timeout) begin
			menu_q <= MN_DISPLAY;
		end else begin
			case (menu_q)
				MN_DISPLAY: begin
					// Entry only while the direct menu is on
					if (combo_press && acsp_q) begin
						chan_sel_q <= 1'b0;
						if (code_q == CODE_OPEN) begin
							menu_q <= MN_SP_PROMPT;
						end else begin
							menu_q <= MN_CODE_PROMPT;
						end
					end
				end
				MN_CODE_PROMPT: begin
					if (btn_press[BTN_NEXT]) begin
						edit_code_q <= 16'h0000;
						digit_q <= 3'(CODE_DIGITS - 1);
						menu_q <= MN_CODE_EDIT;
					end else if (btn_press[BTN_EXIT]) begin
						menu_q <= MN_DISPLAY;
					end
				end
				MN_CODE_EDIT: begin
					// Flashing digit edited in place, next moves on
					if (btn_press[BTN_UP] || btn_press[BTN_DOWN]) begin
						edit_code_q[digit_q[1:0]*4 +: 4] <= bcd_step(
							edit_code_q[digit_q[1:0]*4 +: 4],
							btn_press[BTN_UP]);
					end else if (btn_press[BTN_NEXT]) begin
						digit_q <= (digit_q == 3'h0) ?
							3'(CODE_DIGITS - 1) : digit_q - 3'h1;
					end else if (btn_press[BTN_EXIT]) begin
						// Wrong code drops straight back to display
						menu_q <= (edit_code_q == code_q) ?
							MN_SP_PROMPT : MN_DISPLAY;
					end
				end
				MN_SP_PROMPT: begin
					if (btn_press[BTN_UP] || btn_press[BTN_DOWN]) begin
						chan_sel_q <= ~chan_sel_q;
					end else if (btn_press[BTN_NEXT]) begin
						edit_val_q <= sp_q[chan_sel_q];
						digit_q <= 3'(SP_DIGITS - 1);
						menu_q <= MN_SP_EDIT;
					end else if (btn_press[BTN_EXIT]) begin
						menu_q <= MN_DISPLAY;
					end
				end
				MN_SP_EDIT: begin
					// Up/down move by the weight of the flashing digit
					if (btn_press[BTN_UP]) begin
						edit_val_q <= sp_clamp(20'(edit_val_q) +
							20'(DIGIT_WEIGHT[digit_q]));
					end else if (btn_press[BTN_DOWN]) begin
						edit_val_q <= sp_clamp(20'(edit_val_q) -
							20'(DIGIT_WEIGHT[digit_q]));
					end else if (btn_press[BTN_NEXT]) begin
						digit_q <= (digit_q == 3'h0) ?
							3'(SP_DIGITS - 1) : digit_q - 3'h1;
					end else if (btn_press[BTN_EXIT]) begin
						menu_q <= MN_SP_PROMPT;
					end
				end
				default: begin
					menu_q <= MN_DISPLAY;
				end
			endcase
		end
	end

	// Setpoint storage; the configuration load takes precedence
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sp_q[0] <= SP_RESET;
			sp_q[1] <= SP_RESET;
		end else if (sp_load) begin
			sp_q[sp_load_chan] <= sp_clamp(20'(sp_load_value));
		end else if (sp_store) begin
			sp_q[chan_sel_q] <= edit_val_q;
		end
	end

	// Direct menu enable and its own code, factory state at reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acsp_q <= ACSP_RESET;
			code_q <= CODE_RESET;
		end else if (menu_cfg_load) begin
			acsp_q <= direct_trip_point_menu_in;
			code_q <= direct_menu_code_in;
		end
	end

	// ---------------------------------------------------------------
	// Alarm channels
	// ---------------------------------------------------------------
	dsal_chan_state_t ch_q [2]; // Channel state
	logic [1:0] flash_ok; // Output active with display flashing wanted
	logic accept_go; // Accept press outside the menu
	assign accept_go = accept_press && (menu_q == MN_DISPLAY);

	for (genvar c = 0; c < 2; c++) begin : g_chan
		logic cond_q; // Alarm condition with hysteresis
		logic cond_d;
		logic [11:0] cnt_q; // Seconds spent delayed or silenced
		logic [11:0] dly; // Delay clipped to its range
		logic [11:0] sil; // Silence clipped to its range
		logic signed [19:0] val;
		logic signed [19:0] sp;
		logic signed [19:0] hys;

		assign val = 20'(display_value);
		assign sp = 20'(sp_q[c]);
		assign hys = 20'($signed({1'b0, chan_cfg[c].deadband_value}));
		assign dly = (chan_cfg[c].activation_delay > TIME_MAX_S) ?
			TIME_MAX_S : chan_cfg[c].activation_delay;
		assign sil = (chan_cfg[c].silence_time > TIME_MAX_S) ?
			TIME_MAX_S : chan_cfg[c].silence_time;

		// Condition sets on reaching the setpoint, clears past the band
		always_comb begin
			cond_d = 1'b0;
			if (!chan_cfg[c].enable) begin
				cond_d = 1'b0;
			end else if (chan_cfg[c].high_low_select) begin
				cond_d = cond_q ? !(val < sp - hys)
					: (val >= sp);
			end else begin
				cond_d = cond_q ? !(val > sp + hys)
					: (val <= sp);
			end
		end

		// Condition register
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				cond_q <= 1'b0;
			end else begin
				cond_q <= cond_d;
			end
		end

		// Delay, activation and silence sequencing
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				ch_q[c] <= CH_IDLE;
				cnt_q <= 12'h000;
			end else if (!cond_q) begin
				// Any break in the condition restarts the sequence
				ch_q[c] <= CH_IDLE;
				cnt_q <= 12'h000;
			end else begin
				case (ch_q[c])
					CH_IDLE: begin
						cnt_q <= 12'h000;
						ch_q[c] <= (dly == 12'h000) ?
							CH_ACTIVE : CH_DELAY;
					end
					CH_DELAY: begin
						if (sec_tick) begin
							cnt_q <= cnt_q + 12'h001;
							if (cnt_q + 12'h001 >= dly) begin
								ch_q[c] <= CH_ACTIVE;
							end
						end
					end
					CH_ACTIVE: begin
						if (accept_go && sil != 12'h000) begin
							cnt_q <= 12'h000;
							ch_q[c] <= CH_SILENCE;
						end
					end
					CH_SILENCE: begin
						if (sec_tick) begin
							cnt_q <= cnt_q + 12'h001;
							if (cnt_q + 12'h001 >= sil) begin
								ch_q[c] <= CH_ACTIVE;
							end
						end
					end
					default: begin
						ch_q[c] <= CH_IDLE;
					end
				endcase
			end
		end

		// Registered outputs: switch sense and annunciator
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				alarm_switch_closed[c] <= 1'b0;
				annunciator_on[c] <= 1'b0;
			end else begin
				alarm_switch_closed[c] <= chan_cfg[c].normally_closed ^
					(ch_q[c] == CH_ACTIVE);
				case (ch_q[c])
					CH_ACTIVE: annunciator_on[c] <= 1'b1;
					CH_DELAY: annunciator_on[c] <= blink_q;
					CH_SILENCE: annunciator_on[c] <= blink_q;
					default: annunciator_on[c] <= 1'b0;
				endcase
			end
		end

		// Only an activated output flashes the display
		assign flash_ok[c] = chan_cfg[c].display_flash_option &&
			(ch_q[c] == CH_ACTIVE);
	end

	// ---------------------------------------------------------------
	// Display alternation
	// ---------------------------------------------------------------
	logic [1:0] seq_q; // Step through value, ref, value, ref

	// Sequence advances once a second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seq_q <= 2'h0;
		end else if (flash_ok == 2'b00) begin
			seq_q <= 2'h0;
		end else if (sec_tick) begin
			seq_q <= seq_q + 2'h1;
		end
	end

	// Odd steps show a reference; both active share them in turn
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			display_select <= DISP_VALUE;
		end else if (!seq_q[0] || flash_ok == 2'b00) begin
			display_select <= DISP_VALUE;
		end else if (flash_ok == 2'b11) begin
			display_select <= seq_q[1] ?
				DISP_REF_TWO : DISP_REF_ONE;
		end else begin
			display_select <= flash_ok[0] ?
				DISP_REF_ONE : DISP_REF_TWO;
		end
	end

	// ---------------------------------------------------------------
	// Status outputs
	// ---------------------------------------------------------------
	assign first_trip_point = sp_q[0];
	assign second_trip_point = sp_q[1];
	assign direct_trip_point_menu = acsp_q;
	assign direct_menu_code = code_q;
	assign menu_stat = '{mode: menu_q, chan: chan_sel_q, digit: digit_q,
		edit_value: edit_val_q, edit_code: edit_code_q};

endmodule

// file: verif/dsal_alarm_logic_assertions.sv
`timescale 1ns/1ps
module dsal_alarm_logic_assertions
	import dsal_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire dsal_value_t display_value,
	input wire dsal_value_t sp_low_limit,
	input wire dsal_value_t sp_high_limit,
	input wire dsal_chan_cfg_t chan_cfg [2],
	input wire logic [3:0] buttons,
	input wire logic sp_load,
	input wire logic sp_load_chan,
	input wire dsal_value_t sp_load_value,
	input wire logic menu_cfg_load,
	input wire logic direct_trip_point_menu_in,
	input wire logic [15:0] direct_menu_code_in,
	input wire logic [1:0] alarm_switch_closed,
	input wire logic [1:0] annunciator_on,
	input wire dsal_disp_t display_select,
	input wire dsal_value_t first_trip_point,
	input wire dsal_value_t second_trip_point,
	input wire logic direct_trip_point_menu,
	input wire logic [15:0] direct_menu_code,
	input wire dsal_menu_stat_t menu_stat
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Expected stored setpoint, kept inside the current-loop limits
	function automatic dsal_value_t clampv(dsal_value_t v, dsal_value_t lo,
		dsal_value_t hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	a_sp_first_store: assert property (sp_load && !sp_load_chan |=>
		first_trip_point == clampv($past(sp_load_value),
		$past(sp_low_limit), $past(sp_high_limit)))
		else $error("first setpoint not stored clamped");
	a_sp_second_store: assert property (sp_load && sp_load_chan |=>
		second_trip_point == clampv($past(sp_load_value),
		$past(sp_low_limit), $past(sp_high_limit)))
		else $error("second setpoint not stored clamped");
	a_menu_cfg_store: assert property (menu_cfg_load |=>
		direct_trip_point_menu == $past(direct_trip_point_menu_in) &&
		direct_menu_code == $past(direct_menu_code_in))
		else $error("direct menu settings not stored");
	a_menu_blocked: assert property (!direct_trip_point_menu &&
		menu_stat.mode == MN_DISPLAY |=> menu_stat.mode == MN_DISPLAY)
		else $error("setpoint menu reached while disabled");
	a_open_code_skip: assert property (direct_trip_point_menu &&
		direct_menu_code == CODE_OPEN && !menu_cfg_load &&
		menu_stat.mode == MN_DISPLAY |=> menu_stat.mode != MN_CODE_PROMPT)
		else $error("code asked although code is open");
	a_off_sense_idle: assert property ((!chan_cfg[0].enable &&
		$stable(chan_cfg[0].normally_closed)) [*4] |->
		alarm_switch_closed[0] == chan_cfg[0].normally_closed)
		else $error("idle switch sense wrong");
	a_off_annunc_dark: assert property (!chan_cfg[1].enable [*4] |->
		!annunciator_on[1])
		else $error("annunciator lit on disabled channel");
	a_high_trip_direct: assert property ((chan_cfg[0].enable &&
		chan_cfg[0].high_low_select && chan_cfg[0].activation_delay == 12'h000
		&& chan_cfg[0].silence_time == 12'h000 && $stable(chan_cfg[0]) &&
		display_value >= first_trip_point) [*4] |->
		alarm_switch_closed[0] != chan_cfg[0].normally_closed)
		else $error("high alarm did not trip at setpoint");
	a_flash_off_value: assert property ((!chan_cfg[0].display_flash_option
		&& !chan_cfg[1].display_flash_option) [*3] |->
		display_select == DISP_VALUE)
		else $error("display alternates with flashing off");
endmodule

// file: verif/dsal_operator_model.sv
`timescale 1ns/1ps
// Operator at the push buttons and the loads behind the alarm switches
module dsal_operator_model
	import dsal_pkg::*;
#(
	parameter int HOLD = 6 // Cycles pressed, then cycles released
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] press_req,
	input wire logic press_go,
	input wire logic [1:0] alarm_switch_closed,
	output logic [3:0] buttons,
	output logic press_busy,
	output logic [1:0] load_energised
);
	logic [4:0] hold_q; // Remaining cycles of press plus release

	// Press the set, hold it, then release long enough for the sync
	// stages; a press is never shorter than the sync path needs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			buttons <= 4'h0;
			press_busy <= 1'b0;
			hold_q <= 5'h00;
		end else if (press_go && !press_busy) begin
			buttons <= press_req;
			press_busy <= 1'b1;
			hold_q <= 5'(2 * HOLD);
		end else if (hold_q != 5'h00) begin
			hold_q <= hold_q - 5'h01;
			if (hold_q == 5'(HOLD + 1)) begin // Release between presses
				buttons <= 4'h0;
			end
			if (hold_q == 5'h01) begin
				press_busy <= 1'b0;
			end
		end
	end

	// Load is powered through a closed switch
	assign load_energised = alarm_switch_closed;
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb
	import dsal_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b1;
	dsal_value_t display_value, sp_load_value;
	dsal_value_t sp_low_limit, sp_high_limit;
	dsal_chan_cfg_t chan_cfg [2];
	logic [3:0] buttons, press_req;
	logic sp_load, sp_load_chan, menu_cfg_load, direct_trip_point_menu_in;
	logic [15:0] direct_menu_code_in, direct_menu_code;
	logic [1:0] alarm_switch_closed, annunciator_on, load_energised;
	dsal_disp_t display_select;
	dsal_value_t first_trip_point, second_trip_point;
	logic direct_trip_point_menu, press_go, press_busy;
	dsal_menu_stat_t menu_stat;
	int mismatches = 0;
	int n_compared = 0;
	int n;
	logic [1:0] ann_seen; // Annunciator levels seen while waiting
	logic [2:0] disp_seen; // Display selections seen

	always #12.5 clk = ~clk;

	dsal_alarm_logic #(.TICK_LEN(20)) uut (.clk, .resetn, .display_value,
		.sp_low_limit, .sp_high_limit, .chan_cfg, .buttons, .sp_load,
		.sp_load_chan, .sp_load_value, .menu_cfg_load,
		.direct_trip_point_menu_in, .direct_menu_code_in,
		.alarm_switch_closed, .annunciator_on, .display_select,
		.first_trip_point, .second_trip_point, .direct_trip_point_menu,
		.direct_menu_code, .menu_stat);
	dsal_operator_model op (.clk, .resetn, .press_req, .press_go,
		.alarm_switch_closed, .buttons, .press_busy, .load_energised);

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task complete_run;
		$display("mismatches=%0d compared=%0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task timeout;
		mismatches++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1);
		complete_run();
	endtask

	function automatic dsal_chan_cfg_t mk(logic en, logic hi, logic nc,
		logic fl, logic [15:0] hy, logic [11:0] dl, logic [11:0] sl);
		return '{en, hi, nc, fl, hy, dl, sl};
	endfunction

	// One press of a button set, bounded wait for release
	task automatic press(input logic [3:0] b);
		@(posedge clk);
		press_req <= b;
		press_go <= 1'b1;
		@(posedge clk);
		press_go <= 1'b0;
		for (int i = 0; i <= 60; i++) begin
			@(posedge clk);
			if (!press_busy) break;
			if (i == 60) timeout();
		end
		#1;
	endtask

	// Wait for a load level, noting the annunciator meanwhile
	task automatic wait_sw(input int ch, input logic v, input int lim,
		output int cnt);
		ann_seen = 2'b00;
		for (cnt = 0; cnt <= lim; cnt++) begin
			@(posedge clk);
			#1;
			if (annunciator_on[ch]) ann_seen[1] = 1'b1;
			else ann_seen[0] = 1'b1;
			if (load_energised[ch] === v) return;
		end
		timeout();
	endtask

	task automatic ld(input logic ch, input dsal_value_t v);
		@(posedge clk);
		sp_load <= 1'b1;
		sp_load_chan <= ch;
		sp_load_value <= v;
		@(posedge clk);
		sp_load <= 1'b0;
		#1;
	endtask

	task automatic mcfg(input logic on, input logic [15:0] code);
		@(posedge clk);
		menu_cfg_load <= 1'b1;
		direct_trip_point_menu_in <= on;
		direct_menu_code_in <= code;
		@(posedge clk);
		menu_cfg_load <= 1'b0;
	endtask

	task automatic val(input dsal_value_t v);
		@(posedge clk);
		display_value <= v;
	endtask

	task automatic watch(input int k);
		disp_seen = 3'b000;
		repeat (k) begin
			@(posedge clk);
			#1;
			disp_seen[display_select] = 1'b1;
		end
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		display_value = 18'sh00000;
		sp_low_limit = 18'sh3ff83;
		sp_high_limit = 18'sh0278d;
		chan_cfg[0] = mk(0, 1, 1, 0, 16'h00c8, 12'h003, 12'h000);
		chan_cfg[1] = mk(0, 0, 0, 0, 16'h0000, 12'h000, 12'h000);
		{sp_load, sp_load_chan, menu_cfg_load, press_go} = 4'h0;
		sp_load_value = 18'sh00000;
		direct_trip_point_menu_in = 1'b0;
		direct_menu_code_in = 16'h0000;
		press_req = 4'h0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk(direct_trip_point_menu, 1'b0);
		chk(direct_menu_code, 16'h0000);
		chk(first_trip_point, 18'sh00000);
		ld(0, 18'sh04e20);
		chk(first_trip_point, 18'sh0278d);
		ld(0, 18'sh3fe0c);
		chk(first_trip_point, 18'sh3ff83);
		ld(0, 18'sh02328);
		ld(1, 18'sh00064);
		// Delayed high alarm with hysteresis, output closed when idle
		@(posedge clk) chan_cfg[0] <= mk(1, 1, 1, 0, 16'h00c8, 12'h003, 0);
		val(18'sh02327);
		repeat (6) @(posedge clk);
		#1;
		chk(alarm_switch_closed[0], 1'b1);
		chk(annunciator_on[0], 1'b0);
		val(18'sh02328);
		wait_sw(0, 1'b0, 80, n);
		chk(n >= 38 && n <= 66, 1'b1);
		chk(ann_seen, 2'b11);
		repeat (10) @(posedge clk);
		chk(annunciator_on[0], 1'b1);
		val(18'sh02260);
		repeat (8) @(posedge clk);
		#1;
		chk(alarm_switch_closed[0], 1'b0);
		val(18'sh0225f);
		wait_sw(0, 1'b1, 10, n);
		// Zero delay, on/off keeps settings, then accept and silence
		@(posedge clk) chan_cfg[0] <= mk(1, 1, 0, 0, 16'h00c8, 0, 12'h003);
		val(18'sh02328);
		wait_sw(0, 1'b1, 10, n);
		@(posedge clk) chan_cfg[0].enable <= 1'b0;
		wait_sw(0, 1'b0, 10, n);
		chk(first_trip_point, 18'sh02328);
		@(posedge clk) chan_cfg[0].enable <= 1'b1;
		wait_sw(0, 1'b1, 10, n);
		press(4'b0100);
		chk(alarm_switch_closed[0], 1'b0);
		wait_sw(0, 1'b1, 70, n);
		chk(ann_seen, 2'b11);
		chk(n >= 20, 1'b1);
		@(posedge clk) chan_cfg[0].silence_time <= 12'h000;
		press(4'b0100);
		chk(alarm_switch_closed[0], 1'b1);
		// Low alarm clears only above setpoint plus hysteresis
		@(posedge clk) chan_cfg[1] <= mk(1, 0, 0, 0, 16'h0032, 0, 0);
		val(18'sh00064);
		wait_sw(1, 1'b1, 10, n);
		val(18'sh00096);
		repeat (6) @(posedge clk);
		#1;
		chk(alarm_switch_closed[1], 1'b1);
		val(18'sh00097);
		wait_sw(1, 1'b0, 10, n);
		// Display alternation, then second reference suppressed during a long delay
		ld(1, 18'sh01f40);
		@(posedge clk) chan_cfg[0] <= mk(1, 1, 0, 1, 0, 0, 0);
		chan_cfg[1] <= mk(1, 1, 0, 1, 0, 0, 0);
		val(18'sh0251c);
		watch(200);
		chk(disp_seen, 3'b111);
		@(posedge clk) chan_cfg[1].activation_delay <= 12'he10;
		val(18'sh00000);
		repeat (6) @(posedge clk);
		val(18'sh0251c);
		watch(200);
		chk(disp_seen, 3'b011);
		// Direct setpoint menu
		press(4'b0110);
		chk(menu_stat.mode, MN_DISPLAY);
		mcfg(1'b1, 16'h0000);
		press(4'b0110);
		chk(menu_stat.mode, MN_SP_PROMPT);
		press(4'b0100);
		chk(menu_stat.edit_value, 18'sh02328);
		chk(menu_stat.digit, 3'h4);
		press(4'b0010);
		chk(menu_stat.edit_value, 18'sh0278d);
		press(4'b0001);
		chk(menu_stat.edit_value, 18'sh0007d);
		press(4'b1000);
		chk(first_trip_point, 18'sh0007d);
		press(4'b1000);
		chk(menu_stat.mode, MN_DISPLAY);
		mcfg(1'b1, 16'h0001);
		press(4'b0110);
		chk(menu_stat.mode, MN_CODE_PROMPT);
		press(4'b0100);
		press(4'b1000);
		chk(menu_stat.mode, MN_DISPLAY);
		press(4'b0110);
		repeat (4) press(4'b0100);
		press(4'b0010);
		chk(menu_stat.edit_code, 16'h0001);
		press(4'b1000);
		chk(menu_stat.mode, MN_SP_PROMPT);
		complete_run();
	end
endmodule

bind dsal_alarm_logic dsal_alarm_logic_assertions chk_i (.clk, .resetn,
	.display_value, .sp_low_limit, .sp_high_limit, .chan_cfg, .buttons,
	.sp_load, .sp_load_chan, .sp_load_value, .menu_cfg_load,
	.direct_trip_point_menu_in, .direct_menu_code_in, .alarm_switch_closed,
	.annunciator_on, .display_select, .first_trip_point, .second_trip_point,
	.direct_trip_point_menu, .direct_menu_code, .menu_stat);
